// ==== verilog/smseq_top.v ====
// external memory sequencer: sdram, sync rom and static banks
//
// Functional notes
// - refresh may cut a static burst only between 32-bit transfers
// - read type 0/1 gives non-burst timing, 2/3 burst timing
// - burst-aligned beats use first-access time, later beats burst time
// - four-beat bursts on 16/32-bit buses, eight-beat only on 16-bit
// - any reset deasserts every memory control output
// - sync rom config write always issues mode set, length eight if burst
// - at least three sdram clocks after mode set before next command
// - precharge counter bypassed for sync rom, chosen by upper address
// - auto power-down drops clock enable and stops clock, power-up restarts
// - clock enable sampled high on a rising edge before next activate
// - sdram clock is half or quarter of core clock by divide bit
`timescale 1ns/1ps
`include "smseq_defines.vh"
module smseq_top (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        sw_reset_req,
    input  wire        wdt_reset_req,
    input  wire        refresh_req,
    input  wire        sync_rom_cfg_wr,
    input  wire        sync_rom_burst_en,
    input  wire [3:0]  sync_rom_bank_en,
    input  wire [3:0]  sdram_bank_en,
    input  wire        sdram_clock_divide_bit,
    input  wire        auto_powerdown_en,
    input  wire [3:0]  row_precharge_time_low,
    input  wire [3:0]  row_precharge_time_high,
    input  wire [1:0]  static_read_type,
    input  wire [4:0]  first_access_time,
    input  wire [4:0]  burst_access_time,
    input  wire        static_bus_16bit,
    input  wire        static_burst_len8,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire        req_dyn,
    input  wire        req_burst,
    input  wire [27:0] req_addr,
    output wire        sdram_clock_enable_out,
    output wire        sdram_clock_out,
    output wire [3:0]  static_chip_select_n,
    output wire [3:0]  dram_row_select_n,
    output wire        sdram_ras_n,
    output wire        sdram_cas_n,
    output wire        sdram_we_n,
    output wire        output_enable_n,
    output wire        write_enable_n,
    output wire [3:0]  byte_mask_n,
    output wire [25:0] mem_addr,
    output wire        req_ack,
    output wire        xfer_done
);

localparam [7:0] S_RST  = 8'h01;
localparam [7:0] S_IDLE = 8'h02;
localparam [7:0] S_PDN  = 8'h04;
localparam [7:0] S_WAKE = 8'h08;
localparam [7:0] S_ACT  = 8'h10;
localparam [7:0] S_RW   = 8'h20;
localparam [7:0] S_LAT  = 8'h40;
localparam [7:0] S_STAT = 8'h80;

// active-low select with one bank low
function [3:0] cs_onehot_n;
    input [1:0] bank;
    begin
        cs_onehot_n = ~(4'h1 << bank);
    end
endfunction

// wait count for one static beat
function [4:0] beat_time;
    input [3:0] alow;
    input [3:0] amask;
    input       fresh;
    input       burst_mode;
    input [4:0] t_first;
    input [4:0] t_burst;
    begin
        if (fresh || !burst_mode || ((alow & amask) == 4'h0)) begin
            beat_time = t_first;
        end else begin
            beat_time = t_burst;
        end
    end
endfunction

reg [7:0]  state_ff,   nxt_state;
reg [1:0]  ph_ff,      nxt_ph;
reg        sdram_clock_out_ff,   nxt_sdram_clock_out;
reg        clk_run_ff, nxt_clk_run;
reg        cke_ff,     nxt_cke;
reg [2:0]  cmd_ff,     nxt_cmd;
reg [3:0]  dcs_n_ff,   nxt_dcs_n;
reg [3:0]  scs_n_ff,   nxt_scs_n;
reg        oe_n_ff,    nxt_oe_n;
reg        we_n_ff,    nxt_we_n;
reg [3:0]  bm_n_ff,    nxt_bm_n;
reg [25:0] addr_ff,    nxt_addr;
reg        ack_ff,     nxt_ack;
reg        done_ff,    nxt_done;
reg [3:0]  trp_ff,     nxt_trp;
reg [1:0]  gap_ff,     nxt_gap;
reg [4:0]  cnt_ff,     nxt_cnt;
reg [3:0]  beat_ff,    nxt_beat;
reg [27:0] cur_ff,     nxt_cur;
reg        wr_ff,      nxt_wr;
reg        burst_ff,   nxt_burst;
reg        resume_ff,  nxt_resume;
reg        mrs_pend_ff, nxt_mrs_pend;
reg        ref_pend_ff, nxt_ref_pend;

wire       rst_req   = sw_reset_req | wdt_reset_req;
wire       step      = sdram_clock_divide_bit ? (ph_ff == `SMSEQ_PH_LAST)
                                              : ph_ff[0];
wire       len8      = static_burst_len8 & static_bus_16bit;
wire [3:0] nbeats    = burst_ff ? (len8 ? `SMSEQ_BEATS8 : `SMSEQ_BEATS4)
                                : (static_bus_16bit ? `SMSEQ_BEATS2
                                                    : `SMSEQ_BEATS1);
wire [3:0] amask     = (static_bus_16bit && !len8) ? `SMSEQ_ALIGN8B
                                                   : `SMSEQ_ALIGN16B;
wire [27:0] ainc     = static_bus_16bit ? `SMSEQ_INC16 : `SMSEQ_INC32;
wire [27:0] next_a   = cur_ff + ainc;
wire       is_rom    = cur_ff[`SMSEQ_ROM_BIT];
wire [1:0] bank      = cur_ff[`SMSEQ_BANK_HI:`SMSEQ_BANK_LO];
wire [3:0] trp_sel   = bank[1] ? row_precharge_time_high
                               : row_precharge_time_low;
// a 32-bit boundary on a 16-bit bus is after the odd halfword
wire       boundary  = static_bus_16bit ? cur_ff[1] : 1'b1;
wire       cmd_ok    = (gap_ff == 2'h0);

always @* begin
    nxt_state    = state_ff;
    nxt_ph       = ph_ff + 2'h1;
    nxt_clk_run  = clk_run_ff;
    nxt_cke      = cke_ff;
    nxt_cmd      = cmd_ff;
    nxt_dcs_n    = dcs_n_ff;
    nxt_scs_n    = scs_n_ff;
    nxt_oe_n     = oe_n_ff;
    nxt_we_n     = we_n_ff;
    nxt_bm_n     = bm_n_ff;
    nxt_addr     = addr_ff;
    nxt_ack      = 1'b0;
    nxt_done     = 1'b0;
    nxt_trp      = trp_ff;
    nxt_gap      = gap_ff;
    nxt_cnt      = cnt_ff;
    nxt_beat     = beat_ff;
    nxt_cur      = cur_ff;
    nxt_wr       = wr_ff;
    nxt_burst    = burst_ff;
    nxt_resume   = resume_ff;
    nxt_mrs_pend = mrs_pend_ff;
    nxt_ref_pend = ref_pend_ff;
    if (step) begin
        // commands last one sdram clock, static pins are refreshed below
        nxt_cmd   = `SMSEQ_CMD_NOP;
        nxt_dcs_n = 4'hF;
        nxt_scs_n = 4'hF;
        nxt_oe_n  = 1'b1;
        nxt_we_n  = 1'b1;
        nxt_bm_n  = 4'hF;
        if (gap_ff != 2'h0) begin
            nxt_gap = gap_ff - 2'h1;
        end
        if (trp_ff != 4'h0) begin
            nxt_trp = trp_ff - 4'h1;
        end
        if (rst_req && state_ff != S_LAT) begin
            // abandoning before the read command leaves no driver behind
            nxt_state   = S_RST;
            nxt_cke     = 1'b0;
            nxt_clk_run = 1'b0;
            nxt_resume  = 1'b0;
        end else begin
            case (state_ff)
            S_RST: begin
                nxt_state   = S_IDLE;
                nxt_cke     = 1'b1;
                nxt_clk_run = 1'b1;
            end
            S_IDLE: begin
                if (ref_pend_ff) begin
                    if (cmd_ok && trp_ff == 4'h0) begin
                        nxt_cmd      = `SMSEQ_CMD_REF;
                        nxt_dcs_n    = ~sdram_bank_en;
                        nxt_trp      = row_precharge_time_low;
                        nxt_ref_pend = 1'b0;
                    end
                end else if (mrs_pend_ff) begin
                    if (cmd_ok) begin
                        nxt_cmd      = `SMSEQ_CMD_MRS;
                        nxt_scs_n    = ~sync_rom_bank_en;
                        nxt_addr     = sync_rom_burst_en ? `SMSEQ_MODE_BL8
                                                         : `SMSEQ_MODE_BL1;
                        nxt_gap      = `SMSEQ_MRS_GAP;
                        nxt_mrs_pend = 1'b0;
                    end
                end else if (resume_ff) begin
                    // a cut burst restarts as a fresh access
                    nxt_resume = 1'b0;
                    nxt_state  = S_STAT;
                    nxt_cnt    = first_access_time;
                end else if (req_valid && cmd_ok) begin
                    nxt_ack   = 1'b1;
                    nxt_cur   = req_addr;
                    nxt_wr    = req_write;
                    nxt_burst = req_burst;
                    nxt_beat  = 4'h0;
                    if (req_dyn) begin
                        nxt_state = S_ACT;
                    end else begin
                        nxt_state = S_STAT;
                        nxt_cnt   = first_access_time;
                    end
                end else if (auto_powerdown_en) begin
                    nxt_state   = S_PDN;
                    nxt_cke     = 1'b0;
                    nxt_clk_run = 1'b0;
                    nxt_cnt     = `SMSEQ_PD_MIN;
                end
            end
            S_PDN: begin
                // at least two periods low, above the 1.5 clock minimum
                if (cnt_ff != 5'h00) begin
                    nxt_cnt = cnt_ff - 5'h01;
                end else if (req_valid || ref_pend_ff || mrs_pend_ff ||
                             !auto_powerdown_en) begin
                    nxt_state   = S_WAKE;
                    nxt_cke     = 1'b1;
                    nxt_clk_run = 1'b1;
                    nxt_trp     = trp_sel;
                end
            end
            S_WAKE: begin
                // one rise with enable high passes before any activate
                nxt_state = S_IDLE;
            end
            S_ACT: begin
                if (is_rom || trp_ff == 4'h0) begin
                    nxt_cmd  = `SMSEQ_CMD_ACT;
                    nxt_addr = cur_ff[25:0];
                    if (is_rom) begin
                        nxt_scs_n = cs_onehot_n(bank);
                    end else begin
                        nxt_dcs_n = cs_onehot_n(bank);
                    end
                    nxt_state = S_RW;
                end
            end
            S_RW: begin
                nxt_cmd  = wr_ff ? `SMSEQ_CMD_WR : `SMSEQ_CMD_RD;
                nxt_bm_n = 4'h0;
                if (is_rom) begin
                    nxt_scs_n = cs_onehot_n(bank);
                end else begin
                    nxt_dcs_n = cs_onehot_n(bank);
                end
                if (wr_ff) begin
                    nxt_done  = 1'b1;
                    nxt_state = S_IDLE;
                    if (!is_rom) begin
                        nxt_trp = trp_sel;
                    end
                end else begin
                    nxt_cnt   = `SMSEQ_CAS_LAT;
                    nxt_state = S_LAT;
                end
            end
            S_LAT: begin
                // clock keeps running so the read data finishes
                nxt_bm_n = 4'h0;
                if (cnt_ff == 5'h01) begin
                    nxt_done  = 1'b1;
                    nxt_state = S_IDLE;
                    if (!is_rom) begin
                        nxt_trp = trp_sel;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 5'h01;
                end
            end
            S_STAT: begin
                nxt_scs_n = cs_onehot_n(bank);
                nxt_oe_n  = wr_ff;
                nxt_we_n  = ~wr_ff;
                nxt_bm_n  = 4'h0;
                nxt_addr  = cur_ff[25:0];
                if (cnt_ff != 5'h00) begin
                    nxt_cnt = cnt_ff - 5'h01;
                end else begin
                    nxt_beat = beat_ff + 4'h1;
                    nxt_cur  = next_a;
                    if (beat_ff + 4'h1 == nbeats) begin
                        nxt_done  = 1'b1;
                        nxt_state = S_IDLE;
                    end else if (boundary && ref_pend_ff) begin
                        nxt_resume = 1'b1;
                        nxt_state  = S_IDLE;
                    end else begin
                        nxt_cnt = beat_time(next_a[3:0], amask, 1'b0,
                                            static_read_type[1],
                                            first_access_time,
                                            burst_access_time);
                    end
                end
            end
            default: begin
                nxt_state = S_RST;
            end
            endcase
        end
    end
    // a new event wins over the clear in the same cycle
    if (sync_rom_cfg_wr) begin
        nxt_mrs_pend = 1'b1;
    end
    if (refresh_req) begin
        nxt_ref_pend = 1'b1;
    end
    // clock output held low while stopped
    nxt_sdram_clock_out = nxt_clk_run &
                (sdram_clock_divide_bit ? nxt_ph[1] : nxt_ph[0]);
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        state_ff    <= S_RST;
        ph_ff       <= 2'h0;
        sdram_clock_out_ff    <= 1'b0;
        clk_run_ff  <= 1'b0;
        cke_ff      <= 1'b0;
        cmd_ff      <= `SMSEQ_CMD_NOP;
        dcs_n_ff    <= 4'hF;
        scs_n_ff    <= 4'hF;
        oe_n_ff     <= 1'b1;
        we_n_ff     <= 1'b1;
        bm_n_ff     <= 4'hF;
        addr_ff     <= 26'h0000000;
        ack_ff      <= 1'b0;
        done_ff     <= 1'b0;
        trp_ff      <= 4'h0;
        gap_ff      <= 2'h0;
        cnt_ff      <= 5'h00;
        beat_ff     <= 4'h0;
        cur_ff      <= 28'h0000000;
        wr_ff       <= 1'b0;
        burst_ff    <= 1'b0;
        resume_ff   <= 1'b0;
        mrs_pend_ff <= 1'b0;
        ref_pend_ff <= 1'b0;
    end else if (clk_en) begin
        state_ff    <= nxt_state;
        ph_ff       <= nxt_ph;
        sdram_clock_out_ff    <= nxt_sdram_clock_out;
        clk_run_ff  <= nxt_clk_run;
        cke_ff      <= nxt_cke;
        cmd_ff      <= nxt_cmd;
        dcs_n_ff    <= nxt_dcs_n;
        scs_n_ff    <= nxt_scs_n;
        oe_n_ff     <= nxt_oe_n;
        we_n_ff     <= nxt_we_n;
        bm_n_ff     <= nxt_bm_n;
        addr_ff     <= nxt_addr;
        ack_ff      <= nxt_ack;
        done_ff     <= nxt_done;
        trp_ff      <= nxt_trp;
        gap_ff      <= nxt_gap;
        cnt_ff      <= nxt_cnt;
        beat_ff     <= nxt_beat;
        cur_ff      <= nxt_cur;
        wr_ff       <= nxt_wr;
        burst_ff    <= nxt_burst;
        resume_ff   <= nxt_resume;
        mrs_pend_ff <= nxt_mrs_pend;
        ref_pend_ff <= nxt_ref_pend;
    end
end

assign sdram_clock_enable_out = cke_ff;
assign sdram_clock_out        = sdram_clock_out_ff;
assign static_chip_select_n   = scs_n_ff;
assign dram_row_select_n      = dcs_n_ff;
assign sdram_ras_n            = cmd_ff[2];
assign sdram_cas_n            = cmd_ff[1];
assign sdram_we_n             = cmd_ff[0];
assign output_enable_n        = oe_n_ff;
assign write_enable_n         = we_n_ff;
assign byte_mask_n            = bm_n_ff;
assign mem_addr               = addr_ff;
assign req_ack                = ack_ff;
assign xfer_done              = done_ff;

endmodule // smseq_top

// ==== inc/smseq_defines.vh ====
// constants for the external memory sequencer
`ifndef SMSEQ_DEFINES_VH
`define SMSEQ_DEFINES_VH
// sdram command codes as {ras_n, cas_n, we_n}
`define SMSEQ_CMD_NOP   3'h7
`define SMSEQ_CMD_ACT   3'h3
`define SMSEQ_CMD_RD    3'h5
`define SMSEQ_CMD_WR    3'h4
`define SMSEQ_CMD_REF   3'h1
`define SMSEQ_CMD_MRS   3'h0
// address map: bit 27 selects sync rom, bits 26:25 the bank index
`define SMSEQ_ROM_BIT   27
`define SMSEQ_BANK_HI   26
`define SMSEQ_BANK_LO   25
// mode word: cas latency 2, burst length 8 or 1
`define SMSEQ_MODE_BL8  26'h0000023
`define SMSEQ_MODE_BL1  26'h0000020
// counts in sdram clock periods
`define SMSEQ_MRS_GAP   2'h2
`define SMSEQ_PD_MIN    5'h01
`define SMSEQ_CAS_LAT   5'h02
// static burst lengths and address steps
`define SMSEQ_BEATS8    4'h8
`define SMSEQ_BEATS4    4'h4
`define SMSEQ_BEATS2    4'h2
`define SMSEQ_BEATS1    4'h1
`define SMSEQ_INC16     28'h0000002
`define SMSEQ_INC32     28'h0000004
`define SMSEQ_ALIGN16B  4'hF
`define SMSEQ_ALIGN8B   4'h7
// last phase of the divider in quarter-rate mode
`define SMSEQ_PH_LAST   2'h3
`endif

// ==== testbench/smseq_checker.sv ====
// concurrent checks on the memory sequencer pins
`timescale 1ns/1ps
module smseq_checker (
    input wire        clk_sys,
    input wire        arst_n,
    input wire        sw_reset_req,
    input wire        wdt_reset_req,
    input wire        sync_rom_cfg_wr,
    input wire        sync_rom_burst_en,
    input wire [3:0]  sync_rom_bank_en,
    input wire        sdram_clock_divide_bit,
    input wire        sdram_clock_enable_out,
    input wire        sdram_clock_out,
    input wire [3:0]  static_chip_select_n,
    input wire [3:0]  dram_row_select_n,
    input wire        sdram_ras_n,
    input wire        sdram_cas_n,
    input wire        sdram_we_n,
    input wire        output_enable_n,
    input wire        write_enable_n,
    input wire [3:0]  byte_mask_n,
    input wire [25:0] mem_addr
);
    wire [2:0] cmd = {sdram_ras_n, sdram_cas_n, sdram_we_n};
    wire       mrs = (cmd == 3'h0);
    reg  [4:0] rq_cnt_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a read in flight may finish first, so wait well past it
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            rq_cnt_ff <= 5'h00;
        else if (!(sw_reset_req || wdt_reset_req))
            rq_cnt_ff <= 5'h00;
        else if (rq_cnt_ff != 5'h1F)
            rq_cnt_ff <= rq_cnt_ff + 5'h01;
    end
    chk_mrs_gap: assert property (
        $rose(mrs) |=> (mrs || cmd == 3'h7)[*5])
        else $error("command too soon after mode set");
    chk_mode_word: assert property (
        mrs |-> mem_addr == (sync_rom_burst_en ? 26'h23 : 26'h20)
            && static_chip_select_n == ~sync_rom_bank_en)
        else $error("mode set word or selects wrong");
    chk_mrs_issued: assert property (
        sync_rom_cfg_wr && !sw_reset_req && !wdt_reset_req
            |-> ##[1:1000] mrs)
        else $error("config write gave no mode set");
    chk_ref_static: assert property (
        cmd == 3'h1 |-> &static_chip_select_n && output_enable_n
            && write_enable_n)
        else $error("refresh during a static beat");
    chk_reset_quiet: assert property (
        rq_cnt_ff >= 5'h18 |-> !sdram_clock_enable_out && !sdram_clock_out
            && &static_chip_select_n && &dram_row_select_n && &cmd
            && output_enable_n && write_enable_n && &byte_mask_n)
        else $error("control pin active under reset request");
    chk_clock_stops: assert property (
        !sdram_clock_enable_out |-> !sdram_clock_out)
        else $error("memory clock runs with enable low");
    chk_pd_min: assert property (
        $fell(sdram_clock_enable_out) && !sw_reset_req && !wdt_reset_req
            |=> !sdram_clock_enable_out[*3])
        else $error("power-down shorter than two periods");
    chk_wake_no_act: assert property (
        $rose(sdram_clock_enable_out) |-> cmd != 3'h3)
        else $error("activate on the wake-up period");
    chk_sdram_clock_out_rate: assert property (
        $rose(sdram_clock_out)
            && $past(sdram_clock_divide_bit, 3) == sdram_clock_divide_bit
            |=> if (sdram_clock_divide_bit)
                (sdram_clock_out ##1 !sdram_clock_out)
            else !sdram_clock_out)
        else $error("memory clock high phase wrong");
endmodule // smseq_checker

bind smseq_top smseq_checker chk_i (.*);

// ==== testbench/smseq_mem_model.sv ====
// passive sdram and sync rom devices watching the pins
`timescale 1ns/1ps
module smseq_mem_model (
    input  wire        clk_sys,
    input  wire        sdram_clock_out,
    input  wire        sdram_clock_enable_out,
    input  wire        sdram_ras_n,
    input  wire        sdram_cas_n,
    input  wire        sdram_we_n,
    input  wire [3:0]  static_chip_select_n,
    input  wire [3:0]  dram_row_select_n,
    input  wire [25:0] mem_addr,
    output reg  [7:0]  n_act,
    output reg  [7:0]  n_ref,
    output reg  [7:0]  n_mrs,
    output reg  [7:0]  viol,
    output reg  [25:0] mode_word,
    output reg  [15:0] act_gap
);
    reg  [15:0] tick = 16'h0000;
    reg  [15:0] last_act = 16'h0000;
    reg  [2:0]  since_mrs = 3'h7;
    reg         cke_seen = 1'h0;
    wire [2:0]  cmd = {sdram_ras_n, sdram_cas_n, sdram_we_n};
    wire        sel = ~&{static_chip_select_n, dram_row_select_n};
    initial begin
        {n_act, n_ref, n_mrs, viol} = 32'h0;
        mode_word = 26'h0;
        act_gap = 16'h0;
    end
    always @(posedge clk_sys) tick <= tick + 16'h0001;
    // a stopped clock gives no edge, so forget the enable at once
    always @(negedge sdram_clock_enable_out) cke_seen <= 1'h0;
    always @(posedge sdram_clock_out) begin
        cke_seen <= sdram_clock_enable_out;
        since_mrs <= (since_mrs == 3'h7) ? since_mrs : since_mrs + 3'h1;
        if (sel && cmd != 3'h7) begin
            if (since_mrs < 3'h2)
                viol <= viol + 8'h01;
            if (cmd == 3'h3 && !(cke_seen && sdram_clock_enable_out))
                viol <= viol + 8'h01;
            if (cmd == 3'h0) begin
                since_mrs <= 3'h0;
                mode_word <= mem_addr;
                n_mrs <= n_mrs + 8'h01;
            end
            if (cmd == 3'h1)
                n_ref <= n_ref + 8'h01;
            if (cmd == 3'h3) begin
                n_act <= n_act + 8'h01;
                act_gap <= tick - last_act;
                last_act <= tick;
            end
        end
    end
endmodule // smseq_mem_model

// ==== testbench/test_smseq_top.sv ====
// random and directed bench for the memory sequencer
`timescale 1ns/1ps
module test_smseq_top;
    reg         clk_sys = 1'h0, arst_n = 1'h0, clk_en = 1'h1;
    reg         sw_reset_req = 1'h0, wdt_reset_req = 1'h0;
    reg         refresh_req = 1'h0, sync_rom_cfg_wr = 1'h0;
    reg         sync_rom_burst_en = 1'h0, sdram_clock_divide_bit = 1'h0;
    reg         auto_powerdown_en = 1'h0, static_bus_16bit = 1'h0;
    reg         static_burst_len8 = 1'h0, req_valid = 1'h0;
    reg         req_write = 1'h0, req_dyn = 1'h0, req_burst = 1'h0;
    reg  [3:0]  sync_rom_bank_en = 4'h3, sdram_bank_en = 4'hC;
    reg  [3:0]  row_precharge_time_low = 4'h8;
    reg  [3:0]  row_precharge_time_high = 4'h8;
    reg  [1:0]  static_read_type = 2'h0;
    reg  [4:0]  first_access_time = 5'h0, burst_access_time = 5'h0;
    reg  [27:0] req_addr = 28'h0;
    wire        sdram_clock_enable_out, sdram_clock_out, req_ack, xfer_done;
    wire        sdram_ras_n, sdram_cas_n, sdram_we_n;
    wire        output_enable_n, write_enable_n;
    wire [3:0]  static_chip_select_n, dram_row_select_n, byte_mask_n;
    wire [25:0] mem_addr;
    wire [7:0]  n_act, n_ref, n_mrs, viol;
    wire [25:0] mode_word;
    wire [15:0] act_gap;
    wire [18:0] pins_on = {sdram_clock_enable_out, sdram_clock_out,
        ~static_chip_select_n, ~dram_row_select_n, ~sdram_ras_n,
        ~sdram_cas_n, ~sdram_we_n, ~output_enable_n, ~write_enable_n,
        ~byte_mask_n};
    integer     failures = 0, check_count = 0, nb, i, k, g0, t0;
    integer     bl [0:15];
    smseq_top dut (.*);
    smseq_mem_model mem (.*);
    always #10 clk_sys = ~clk_sys;
    task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task end_sim;
        begin
            if (failures == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    // beats are timed from the read strobe to each address step
    task xfer(input d, input b, input [27:0] a);
        reg [25:0] pa;
        integer c, n, fin;
        begin
            {req_dyn, req_burst, req_addr, req_valid} = {d, b, a, 1'h1};
            n = 0;
            while (req_ack !== 1'h1 && n < 800) begin
                wt(1);
                n = n + 1;
            end
            req_valid = 1'h0;
            nb = 0;
            c = -1;
            fin = 0;
            // last beat outlives the done pulse, so wait for the strobe
            while (!(fin && output_enable_n !== 1'h0) && n < 3000) begin
                wt(1);
                n = n + 1;
                fin = fin | (xfer_done === 1'h1);
                if (c >= 0)
                    c = c + 1;
                else if (output_enable_n === 1'h0) begin
                    c = 0;
                    pa = mem_addr;
                end
                if (c > 0 && nb < 16 && (mem_addr !== pa
                        || output_enable_n !== 1'h0)) begin
                    bl[nb] = c;
                    nb = nb + 1;
                    c = (output_enable_n === 1'h0) ? 0 : -1;
                    pa = mem_addr;
                end
            end
            chk("done", n < 3000, 1);
        end
    endtask
    function integer blen(input integer j);
        blen = ((static_read_type[1] && j > 0) ? burst_access_time
            : first_access_time) * 2 + 2;
    endfunction
    initial begin
        #1500000;
        failures = failures + 1;
        end_sim;
    end
    initial begin
        k = $urandom(32'h173C7232);
        wt(20);
        arst_n = 1'h1;
        wt(4);
        for (i = 0; i < 12; i = i + 1) begin
            static_read_type = i % 4;
            first_access_time = $urandom % 4;
            burst_access_time = $urandom % 3;
            {static_bus_16bit, static_burst_len8} =
                (i > 9) ? i - 9 : $urandom % 4;
            xfer(1'h0, (i % 4 > 1) || ($urandom % 2 == 1),
                28'h4000000 | ($urandom & 28'h0FFFFF0));
            chk("beats", nb, !req_burst ? 1 + static_bus_16bit
                : (static_bus_16bit && static_burst_len8) ? 8 : 4);
            for (k = 0; k < nb; k = k + 1)
                chk("beat_len", bl[k], blen(k));
        end
        {static_read_type, static_bus_16bit, static_burst_len8} = 4'hB;
        g0 = n_ref;
        fork
            xfer(1'h0, 1'h1, 28'h4000000);
            begin
                wt(9);
                refresh_req = 1'h1;
                wt(1);
                refresh_req = 1'h0;
            end
        join
        wt(6);
        chk("refresh", n_ref, g0 + 1);
        for (i = 0; i < 4; i = i + 1) begin
            g0 = n_mrs;
            sync_rom_burst_en = (i < 2);
            sync_rom_cfg_wr = 1'h1;
            wt(1);
            sync_rom_cfg_wr = 1'h0;
            wt(30);
            chk("mrs", n_mrs, g0 + 1);
            chk("mode", mode_word, (i < 2) ? 26'h23 : 26'h20);
        end
        xfer(1'h1, 1'h0, 28'h8000000);
        xfer(1'h1, 1'h0, 28'h8000000);
        g0 = act_gap;
        xfer(1'h1, 1'h0, 28'h4000000);
        xfer(1'h1, 1'h0, 28'h4000000);
        chk("precharge", act_gap >= g0 + 12, 1);
        auto_powerdown_en = 1'h1;
        wt(40);
        chk("cke_low", {sdram_clock_enable_out, sdram_clock_out}, 0);
        g0 = n_act;
        xfer(1'h1, 1'h0, 28'h4000000);
        chk("wake_act", n_act, g0 + 1);
        auto_powerdown_en = 1'h0;
        wt(10);
        for (i = 0; i < 2; i = i + 1) begin
            sdram_clock_divide_bit = i;
            wt(12);
            @(posedge sdram_clock_out);
            t0 = $time;
            @(posedge sdram_clock_out);
            chk("sdram_clock_out", ($time - t0) / 20, 2 + 2 * i);
            wt(1);
        end
        // freeze only while the clock is low, a high freeze looks stuck
        @(negedge sdram_clock_out);
        wt(1);
        clk_en = 1'h0;
        wt(6);
        chk("freeze", sdram_clock_out, 0);
        clk_en = 1'h1;
        for (k = 0; k < 3; k = k + 1) begin
            if (k < 2)
                fork
                    xfer(1'h1, 1'h0, 28'h4000000);
                    begin
                        i = 0;
                        while ({sdram_ras_n, sdram_cas_n, sdram_we_n} !== 3'h5
                            && i < 300) begin
                            wt(1);
                            i = i + 1;
                        end
                        {wdt_reset_req, sw_reset_req} = k + 1;
                    end
                join
            else begin
                arst_n = 1'h0;
                #1;
                chk("arst_pins", pins_on, 0);
                chk("arst_addr", mem_addr, 0);
            end
            wt(30);
            chk("quiet", pins_on, 0);
            {wdt_reset_req, sw_reset_req, arst_n} = 3'h1;
            wt(20);
            chk("cke_back", sdram_clock_enable_out, 1);
        end
        {sdram_bank_en, sync_rom_bank_en} = 8'h00;
        sw_reset_req = 1'h1;
        wt(30);
        chk("drained", pins_on, 0);
        chk("model", viol, 0);
        end_sim;
    end
endmodule // test_smseq_top
